// ### logic/quad_driver_spi_fault.sv
// How it works
// (RULE_01) Overvoltage forces all four channels off
// (RULE_02) Persistent overcurrent sets channel fault bit
// (RULE_03) Overcurrent fault holds until chip select rises
// (RULE_04) Persisting overcurrent gives low duty drive
// (RULE_05) Open load off only, overcurrent on only
// (RULE_06) Persistent open load sets fault bit
// (RULE_07) Sample input on rising clock, 8/16 bits
// (RULE_08) Master sends most significant bit first
// (RULE_09) Output tristated while chip select high
// (RULE_10) Output updates on falling serial clock
// (RULE_11) Status bit 7 first, bits 0-3 faults
// (RULE_12) Shifting only while chip select low
// (RULE_13) Chip select rise latches last four bits
// (RULE_14) Open chip select reads deasserted
// (RULE_15) Channel on is parallel OR serial bit
// (RULE_16) Open parallel input reads low
// (RULE_17) Status pin low on any fault
// (RULE_18) Controller reads bits after status asserts
// (RULE_19) Chip select fall captures gathered faults
// (RULE_20) Sixteen-bit frame echoes previous first byte
// (RULE_21) Bit n drives channel n, upper zeros
// (RULE_22) Reset clears control latch and faults
`timescale 1ns/1ps
`default_nettype none
module quad_driver_spi_fault
  import quad_driver_pkg::*;
#(
  parameter int unsigned SENSE_CNT = SENSE_CYCLES,
  parameter int unsigned DUTY_PER  = DUTY_PERIOD_CYCLES,
  parameter int unsigned DUTY_ON   = DUTY_ON_CYCLES
)(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                serial_clock,
  input  wire logic                chip_select_n,
  input  wire logic                serial_in,
  output logic                     serial_out,
  output logic                     serial_out_oe,
  input  wire logic                parallel_drive_0,
  input  wire logic                parallel_drive_1,
  input  wire logic                parallel_drive_2,
  input  wire logic                parallel_drive_3,
  input  wire detect_t [CHANNELS-1:0] detect,
  input  wire logic                load_supply_over,
  output logic                     low_side_ch0,
  output logic                     low_side_ch1,
  output logic                     low_side_ch2,
  output logic                     low_side_ch3,
  output logic                     status_out,
  output logic                     status_oe
);

  // ***********************************************
  // Link domain: shift on serial_clock
  // ***********************************************
  // The serial clock only runs inside a frame; everything that must end with
  // the frame is handed to the core domain via the synchronised chip select.
  //
  // Frame timing, as seen from the link side:
  //   Select falls:  output enable rises, bit 7 of the reply shows at once
  //                  through the combinational path below.
  //   Rise 1..n:     one input bit is shifted in per rise, first bit first.
  //   Fall 1:        the output shifter loads the rest of the reply word.
  //   Fall 2..n:     one reply bit per fall; in a long frame the echo of the
  //                  previous first byte follows the eight status bits.
  //   Select rises:  counters and output shifter clear at once; the core
  //                  side picks up the last four bits a few cycles later.
  //
  // Hazards:
  //   The fault snapshot is written by the core clock just after select
  //   falls. The master must leave a few core cycles before the first
  //   serial fall, or the reply shows the previous snapshot.
  //   The receive shifter is read by the core clock only after select has
  //   risen, when no serial edges arrive, so it is quasi-static there.
  //   The echo register has no reset; it holds unknown data until the
  //   first frame of eight bits or more.
  logic [FRAME_BITS-1:0]  rx_shift_ff;
  logic [CNT_W-1:0]       rx_count_ff;
  logic [STATUS_BITS-1:0] echo_ff;
  logic [FRAME_BITS-1:0]  tx_shift_ff;
  logic                   tx_loaded_ff;
  logic                   so_ff;
  logic                   sel;
  logic [STATUS_BITS-1:0] status_word;
  logic [CHANNELS-1:0]    snap_ff;

  // Pull-up is external; treat the pin as given
  assign sel = !chip_select_n;  // [RULE_14]

  always_ff @(posedge serial_clock or posedge chip_select_n)
  begin
    if (chip_select_n)
      rx_count_ff <= 5'h00;
    else if (rx_count_ff != 5'h1f)
      rx_count_ff <= rx_count_ff + 5'h01;
  end

  always_ff @(posedge serial_clock)
  begin
    if (sel)  // [RULE_12]
      rx_shift_ff <= {rx_shift_ff[FRAME_BITS-2:0], serial_in};  // [RULE_07] [RULE_08]
  end

  // First byte of every frame of eight bits or more is kept as the echo for the next frame
  always_ff @(posedge serial_clock)
  begin
    if (sel && rx_count_ff == SHORT_FRAME - 5'h01)
      echo_ff <= {rx_shift_ff[STATUS_BITS-2:0], serial_in};  // [RULE_20]
  end

  assign status_word = {{(STATUS_BITS-CHANNELS){1'b0}}, snap_ff};  // [RULE_21] [RULE_11]

  // Output shifter loads the captured status on the first falling edge window
  always_ff @(negedge serial_clock or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      tx_loaded_ff <= 1'b0;
      tx_shift_ff  <= 16'h0000;
      so_ff        <= 1'b0;
    end
    else if (!tx_loaded_ff)
    begin
      tx_loaded_ff <= 1'b1;
      tx_shift_ff  <= {status_word[STATUS_BITS-3:0], echo_ff, 2'h0};
      so_ff        <= status_word[STATUS_BITS-2];  // [RULE_10]
    end
    else
    begin
      tx_shift_ff <= {tx_shift_ff[FRAME_BITS-2:0], 1'b0};
      so_ff       <= tx_shift_ff[FRAME_BITS-1];  // [RULE_10]
    end
  end

  // Bit 7 is presented as soon as chip select falls
  always_comb
  begin
    serial_out_oe = sel;  // [RULE_09]
    if (!sel)
      serial_out = 1'b0;
    else if (!tx_loaded_ff)
      serial_out = status_word[STATUS_BITS-1];  // [RULE_11]
    else
      serial_out = so_ff;
  end

  // ***********************************************
  // Core domain: chip select synchroniser
  // ***********************************************
  logic        cs_meta_ff;
  logic        cs_sync_ff;
  logic        cs_prev_ff;
  logic        cs_rise;
  logic        cs_fall;

  // Reset to the idle (deselected) level so no false edge follows reset
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cs_meta_ff <= 1'b1;
      cs_sync_ff <= 1'b1;
    end
    else
    begin
      cs_meta_ff <= chip_select_n;
      cs_sync_ff <= cs_meta_ff;
    end
  end

  // Edge detector on the synchronised select
  always_ff @(posedge clock)
  begin
    if (rst)
      cs_prev_ff <= 1'b1;
    else
      cs_prev_ff <= cs_sync_ff;
  end

  assign cs_rise = cs_sync_ff && !cs_prev_ff;
  assign cs_fall = !cs_sync_ff && cs_prev_ff;

  // ***********************************************
  // Core domain: channel control latch
  // ***********************************************
  // The receive shifter is static once chip select is high, so it is read
  // safely on the third core clock edge after the rise.
  logic [CHANNELS-1:0] ctrl_ff;

  always_ff @(posedge clock)
  begin
    if (rst)
      ctrl_ff <= CTRL_RESET;  // [RULE_22]
    else if (cs_rise)
      ctrl_ff <= rx_shift_ff[CHANNELS-1:0];  // [RULE_13] [RULE_21]
  end

  // ***********************************************
  // Core domain: pin synchronisers
  // ***********************************************
  logic [CHANNELS-1:0] par_meta_ff;
  logic [CHANNELS-1:0] par_sync_ff;
  logic                ov_meta_ff;
  logic                ov_sync_ff;
  detect_t [CHANNELS-1:0] det_meta_ff;
  detect_t [CHANNELS-1:0] det_sync_ff;
  logic [CHANNELS-1:0] par_pins;

  // Every level pin passes two flops before logic reads it, so a pin that
  // moves near the clock edge cannot split one decision in two.
  assign par_pins = {parallel_drive_3, parallel_drive_2, parallel_drive_1, parallel_drive_0};

  // Pull-downs are external; an open pin arrives as low
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      par_meta_ff <= 4'h0;
      par_sync_ff <= 4'h0;  // [RULE_16]
    end
    else
    begin
      par_meta_ff <= par_pins;
      par_sync_ff <= par_meta_ff;
    end
  end

  // Overvoltage flag from the supply monitor
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ov_meta_ff <= 1'b0;
      ov_sync_ff <= 1'b0;
    end
    else
    begin
      ov_meta_ff <= load_supply_over;
      ov_sync_ff <= ov_meta_ff;
    end
  end

  // Detector levels, overcurrent and open load per channel
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      det_meta_ff <= '0;
      det_sync_ff <= '0;
    end
    else
    begin
      det_meta_ff <= detect;
      det_sync_ff <= det_meta_ff;
    end
  end

  // ***********************************************
  // Per-channel fault logic
  // ***********************************************
  logic [CHANNELS-1:0] cmd_on;
  logic [CHANNELS-1:0] fault;
  logic [CHANNELS-1:0] drive;
  logic [CHANNELS-1:0] out_ff;

  // Overvoltage also gates the command, so fault timers see the channel off
  // and a returning supply restores the programmed state directly.
  assign cmd_on = (ctrl_ff | par_sync_ff) & {CHANNELS{!ov_sync_ff}};  // [RULE_15] [RULE_01]

  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_ch
    fault_channel #(
      .SENSE_CNT (SENSE_CNT),
      .DUTY_PER  (DUTY_PER),
      .DUTY_ON   (DUTY_ON)
    ) u_ch (
      .clock        (clock),
      .rst          (rst),
      .commanded_on (cmd_on[i]),
      .detect       (det_sync_ff[i]),
      .clear_pulse  (cs_rise),
      .fault_ff     (fault[i]),
      .drive_on     (drive[i])
    );
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      out_ff <= 4'h0;  // [RULE_22]
    else
      out_ff <= drive & {CHANNELS{!ov_sync_ff}};  // [RULE_01]
  end

  assign low_side_ch0 = out_ff[0];
  assign low_side_ch1 = out_ff[1];
  assign low_side_ch2 = out_ff[2];
  assign low_side_ch3 = out_ff[3];

  // ***********************************************
  // Fault snapshot for the serial reply
  // ***********************************************
  // Written once just after chip select falls, then held for the rest of the frame, so the link domain may read it.
  // Faults flagged after the select fall wait for the next frame.
  always_ff @(posedge clock)
  begin
    if (rst)
      snap_ff <= FAULT_RESET;
    else if (cs_fall)
      snap_ff <= fault;  // [RULE_19]
  end

  // ***********************************************
  // Open-drain status pin
  // ***********************************************
  // Pin is pulled low while any sticky fault flag is set
  logic status_ff;

  always_ff @(posedge clock)
  begin
    if (rst)
      status_ff <= 1'b0;
    else
      status_ff <= |fault;  // [RULE_17]
  end

  assign status_out = 1'b0;
  assign status_oe  = status_ff;  // [RULE_17]

endmodule : quad_driver_spi_fault
`default_nettype wire

// ### logic/quad_driver_pkg.sv
package quad_driver_pkg;

  // ***********************************************
  // Channel count and serial frame layout
  // ***********************************************
  localparam int unsigned CHANNELS     = 4;
  localparam int unsigned STATUS_BITS  = 8;
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned CNT_W        = 5;
  localparam logic [CNT_W-1:0] SHORT_FRAME = 5'h08;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int unsigned CLOCK_MHZ          = 100;
  localparam int unsigned SENSE_TIME_NS      = 62500;
  localparam int unsigned SENSE_CYCLES       = (SENSE_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned DUTY_PERIOD_CYCLES = 6400;
  localparam int unsigned DUTY_ON_CYCLES     = 100;

  // ***********************************************
  // Reset values
  // ***********************************************
  localparam logic [CHANNELS-1:0] CTRL_RESET  = 4'h0;
  localparam logic [CHANNELS-1:0] FAULT_RESET = 4'h0;

  // ***********************************************
  // Per-channel detector inputs
  // ***********************************************
  typedef struct packed {
    logic overcurrent;
    logic open_load;
  } detect_t;

endpackage : quad_driver_pkg

// ### logic/fault_channel.sv
`timescale 1ns/1ps
`default_nettype none
module fault_channel
  import quad_driver_pkg::*;
#(
  parameter int unsigned SENSE_CNT  = SENSE_CYCLES,
  parameter int unsigned DUTY_PER   = DUTY_PERIOD_CYCLES,
  parameter int unsigned DUTY_ON    = DUTY_ON_CYCLES
)(
  input  wire logic    clock,
  input  wire logic    rst,
  input  wire logic    commanded_on,
  input  wire detect_t detect,
  input  wire logic    clear_pulse,
  output logic         fault_ff,
  output logic         drive_on
);

  logic [15:0] oc_cnt_ff;
  logic [15:0] ol_cnt_ff;
  logic [15:0] duty_cnt_ff;
  logic        oc_seen;
  logic        ol_seen;

  // ***********************************************
  // Qualification timers
  // ***********************************************
  always_ff @(posedge clock)
  begin
    if (rst || !commanded_on || !detect.overcurrent)  // [RULE_05]
      oc_cnt_ff <= 16'h0000;
    else if (!oc_seen)
      oc_cnt_ff <= oc_cnt_ff + 16'h0001;
  end

  always_ff @(posedge clock)
  begin
    if (rst || commanded_on || !detect.open_load)  // [RULE_05]
      ol_cnt_ff <= 16'h0000;
    else if (!ol_seen)
      ol_cnt_ff <= ol_cnt_ff + 16'h0001;
  end

  assign oc_seen = (oc_cnt_ff >= 16'(SENSE_CNT - 1)) && detect.overcurrent && commanded_on;
  assign ol_seen = (ol_cnt_ff >= 16'(SENSE_CNT - 1)) && detect.open_load && !commanded_on;

  // ***********************************************
  // Sticky fault flag; a new fault beats the clear
  // ***********************************************
  always_ff @(posedge clock)
  begin
    if (rst)
      fault_ff <= 1'b0;  // [RULE_22]
    else if (oc_seen || ol_seen)
      fault_ff <= 1'b1;  // [RULE_02] [RULE_06]
    else if (clear_pulse)
      fault_ff <= 1'b0;  // [RULE_03]
  end

  // ***********************************************
  // Low duty cycle drive while overcurrent persists
  // ***********************************************
  always_ff @(posedge clock)
  begin
    if (rst || !(commanded_on && detect.overcurrent && fault_ff))
      duty_cnt_ff <= 16'h0000;
    else if (duty_cnt_ff == 16'(DUTY_PER - 1))
      duty_cnt_ff <= 16'h0000;
    else
      duty_cnt_ff <= duty_cnt_ff + 16'h0001;
  end

  always_comb
  begin
    if (commanded_on && detect.overcurrent && fault_ff)
      drive_on = duty_cnt_ff < 16'(DUTY_ON);  // [RULE_04]
    else
      drive_on = commanded_on;
  end

endmodule : fault_channel
`default_nettype wire

// ### verification/quad_driver_checker.sv
`timescale 1ns/1ps
`default_nettype none
module quad_driver_checker
  import quad_driver_pkg::*;
#(
  parameter int unsigned SENSE_CNT = SENSE_CYCLES
)(
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   chip_select_n,
  input wire logic                   serial_out_oe,
  input wire logic                   parallel_drive_0,
  input wire detect_t [CHANNELS-1:0] detect,
  input wire logic                   load_supply_over,
  input wire logic                   low_side_ch0,
  input wire logic                   low_side_ch1,
  input wire logic                   low_side_ch2,
  input wire logic                   low_side_ch3,
  input wire logic                   status_out,
  input wire logic                   status_oe
);
  // ********
  // Port checks
  // ********
  wire logic [3:0] outs = {low_side_ch3, low_side_ch2, low_side_ch1, low_side_ch0};
  logic [15:0]     oc_ff;

  // Cycles of overcurrent on a parallel-driven channel 0
  always_ff @(posedge clock)
    if (rst || load_supply_over || !(detect[0].overcurrent && parallel_drive_0))
      oc_ff <= 16'h0;
    else if (oc_ff != 16'hffff)
      oc_ff <= oc_ff + 16'h1;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_oe_follows_sel: assert property (serial_out_oe == !chip_select_n)
    else $error("serial output enable does not follow select");
  a_reset_clears: assert property ($fell(rst) |-> outs == 4'h0 && !status_oe)
    else $error("outputs not cleared by reset");
  a_overvolt_off: assert property (load_supply_over [*8] |-> outs == 4'h0)
    else $error("channel on during overvoltage");
  a_parallel_or: assert property ((parallel_drive_0 && !load_supply_over
    && !detect[0].overcurrent) [*8] |-> low_side_ch0)
    else $error("parallel input does not turn channel on");
  a_oc_fault_set: assert property (oc_ff == SENSE_CNT + 8 |-> status_oe)
    else $error("overcurrent fault not flagged");
  a_fault_sticky: assert property (chip_select_n [*8] ##0 status_oe |=> status_oe)
    else $error("fault cleared without select rise");
  a_fault_cause: assert property ($rose(status_oe) |-> $past(|detect, 5))
    else $error("fault flagged without detector");
  a_status_low: assert property (status_out == 1'b0)
    else $error("status pin driven high");

  cover property ($rose(status_oe));
  cover property ($rose(chip_select_n));
  cover property (load_supply_over [*8]);
endmodule : quad_driver_checker

bind quad_driver_spi_fault quad_driver_checker #(.SENSE_CNT(SENSE_CNT)) i_quad_driver_checker (
  .clock, .rst, .chip_select_n, .serial_out_oe, .parallel_drive_0, .detect,
  .load_supply_over, .low_side_ch0, .low_side_ch1, .low_side_ch2, .low_side_ch3,
  .status_out, .status_oe);
`default_nettype wire

// ### verification/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic     serial_clock,
  output logic     chip_select_n,
  output logic     serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  // ********
  // Mode 0 master, clock still between frames except in noise()
  // ********
  initial
  begin
    serial_clock = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end

  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0;
    #1 chip_select_n = 1'b0;
    #100;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = w[i];
      #32 serial_clock = 1'b1;
      r = {r[14:0], serial_out};
      #32 serial_clock = 1'b0;
    end
    #32 chip_select_n = 1'b1;
    serial_in = 1'b0;
    #100;
  endtask : xfer

  // Clocks with select high must be ignored
  task automatic noise();
    for (int i = 0; i < 8; i++)
    begin
      serial_in = i[0];
      #32 serial_clock = 1'b1;
      #32 serial_clock = 1'b0;
    end
    serial_in = 1'b0;
  endtask : noise
endmodule : spi_master_model
`default_nettype wire

// ### verification/quad_driver_spi_fault_tb.sv
`timescale 1ns/1ps
`default_nettype none
module quad_driver_spi_fault_tb
  import quad_driver_pkg::*;
;
  // ********
  // Bench
  // ********
  logic clock, rst, serial_clock, chip_select_n, serial_in, serial_out, serial_out_oe;
  logic                   load_supply_over, status_out, status_oe, known;
  logic [3:0]             par, ch, ctrl;
  logic [7:0]             prev;
  logic [15:0]            rx;
  detect_t [CHANNELS-1:0] detect;
  int                     err_count, checks_done, cyc, seed, cnt;

  quad_driver_spi_fault #(.SENSE_CNT(20), .DUTY_PER(64), .DUTY_ON(1)) i_quad_driver_spi_fault (
    .clock, .rst, .serial_clock, .chip_select_n, .serial_in, .serial_out, .serial_out_oe,
    .parallel_drive_0(par[0]), .parallel_drive_1(par[1]), .parallel_drive_2(par[2]),
    .parallel_drive_3(par[3]), .detect, .load_supply_over, .low_side_ch0(ch[0]),
    .low_side_ch1(ch[1]), .low_side_ch2(ch[2]), .low_side_ch3(ch[3]), .status_out, .status_oe);
  spi_master_model i_spi_master_model (
    .serial_clock, .chip_select_n, .serial_in, .serial_out, .serial_out_oe);

  always #5 clock = ~clock;

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk_pin(input logic [3:0] g, input logic [3:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_pin

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk_word

  function automatic logic [3:0] exp_out(input logic [3:0] c, input logic [3:0] p);
    return load_supply_over ? 4'h0 : (c | p);
  endfunction : exp_out

  function automatic logic [15:0] exp_rx(input logic [3:0] st, input int n);
    return (n == 16) ? {4'h0, st, prev} : {12'h000, st};
  endfunction : exp_rx

  // One frame, then the echo, status and channel state are compared
  task automatic send(input logic [15:0] w, input int n, input logic [3:0] st);
    i_spi_master_model.xfer(w, n, rx);
    if (n == 8 || known)
      chk_word(rx, exp_rx(st, n));
    prev = (n == 16) ? w[15:8] : w[7:0];
    known = 1'b1;
    ctrl = w[3:0];
    repeat (10) @(posedge clock);
    #1 chk_pin(ch, exp_out(ctrl, par));
  endtask : send

  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    par = 4'h0;
    detect = '0;
    load_supply_over = 1'b0;
    known = 1'b0;
    {err_count, checks_done, cyc} = '0;
    seed = 32'h30475b72;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    #1 chk_pin(ch, 4'h0);
    chk_pin({3'h0, status_oe}, 4'h0);
    for (int k = 0; k < 12; k++)
    begin
      @(posedge clock);
      par <= 4'($random(seed));
      send(16'($random(seed)), ($random(seed) & 1) ? 16 : 8, 4'h0);
    end
    send(16'h5a0f, 16, 4'h0);
    send(16'h00f0, 16, 4'h0);
    i_spi_master_model.noise();
    repeat (10) @(posedge clock);
    #1 chk_pin(ch, exp_out(ctrl, par));
    @(posedge clock);
    load_supply_over <= 1'b1;
    par <= 4'hf;
    repeat (10) @(posedge clock);
    #1 chk_pin(ch, 4'h0);
    @(posedge clock);
    load_supply_over <= 1'b0;
    repeat (10) @(posedge clock);
    #1 chk_pin(ch, 4'hf);
    @(posedge clock);
    par <= 4'h0;
    send(16'h0000, 8, 4'h0);
    @(posedge clock);
    par <= 4'h1;
    detect[0].overcurrent <= 1'b1;
    detect[3].overcurrent <= 1'b1;
    repeat (30) @(posedge clock);
    #1 chk_pin({3'h0, status_oe}, 4'h1);
    cnt = 0;
    repeat (128)
    begin
      @(posedge clock);
      #1 cnt += ch[0];
    end
    chk_word(16'(cnt), 16'h0002);
    detect[0].overcurrent <= 1'b0;
    repeat (20) @(posedge clock);
    #1 chk_pin({3'h0, status_oe}, 4'h1);
    send(16'h0000, 8, 4'h1);
    chk_pin({3'h0, status_oe}, 4'h0);
    @(posedge clock);
    par <= 4'h2;
    detect[2].open_load <= 1'b1;
    detect[1].open_load <= 1'b1;
    repeat (30) @(posedge clock);
    #1 chk_pin({3'h0, status_oe}, 4'h1);
    detect <= '0;
    send(16'h0000, 8, 4'h4);
    chk_pin({3'h0, status_oe}, 4'h0);
    tally_and_finish();
  end
endmodule : quad_driver_spi_fault_tb
`default_nettype wire
